/* File: ac_firing_pattern_generator.v */
// firing pattern generator for an ac load switch, apb register slave
// assumes zc_in is a square wave from a line zero-cross detector,
// climit_pct comes from the current limit loop on pclk
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "acfpg_consts.vh"

module ac_firing_pattern_generator (
  input wire pclk, // bus and logic clock
  input wire presetn, // async reset, active low
  input wire ce, // clock enable, freezes all state when low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction, high for write
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error, unmapped address
  input wire zc_in, // zero-cross detector, high in positive half
  input wire din1_in, // digital input one
  input wire din2_in, // digital input two
  input wire [6:0] climit_pct, // current limit ceiling, percent
  output reg gate_out, // load switch gate, high to conduct
  output reg ramp_out // high while a start ramp is in progress
);
  // configuration registers
  reg [1:0] method_reg;
  reg [1:0] din1_func_reg;
  reg [1:0] din2_func_reg;
  reg [6:0] setpt_reg;
  reg [15:0] cycle_reg;
  reg [7:0] min_reg;
  reg [7:0] ramp_len_reg;
  // pattern state
  reg zc_prev_reg;
  reg [15:0] tb_reg;
  reg [7:0] run_cnt_reg;
  reg run_on_reg;
  reg pat_reg;
  reg lim_on_reg;
  reg ramp_reg;
  reg [7:0] ramp_cnt_reg;
  reg en_reg;
  reg [19:0] elapsed_reg;
  reg [19:0] period_reg;
  // combinational terms
  reg [6:0] dem;
  reg [6:0] lim;
  reg pat_next;
  reg [15:0] tb_next;
  reg enable;
  reg follow;
  reg follow_lvl;
  reg acc_step;
  reg [6:0] acc_pct;
  reg gate_next;
  reg [31:0] rd_data;
  reg rd_hit;
  wire [2:0] sync_q;
  wire zc_s;
  wire din1_s;
  wire din2_s;
  wire half_edge;
  wire full_edge;
  wire fire;
  wire [7:0] min_eff;
  wire [15:0] cycle_eff;
  wire run_end;
  wire zc_on;
  wire ramp_start;
  wire ramp_last;
  wire [27:0] win_lhs;
  wire [27:0] win_rhs;
  wire win;
  wire on_next;
  wire [22:0] tb_lhs;
  wire [22:0] tb_rhs;
  wire wr_en;
  sync2 #(
    .W(3)
  ) u_sync (
    .clk(pclk),
    .rstn(presetn),
    .ce(ce),
    .d({zc_in, din2_in, din1_in}),
    .q(sync_q)
  );
  assign zc_s = sync_q[2];
  assign din2_s = sync_q[1];
  assign din1_s = sync_q[0];
  // any zero-cross edge ends a half cycle, the rising one a full cycle
  assign half_edge = zc_s ^ zc_prev_reg;
  assign full_edge = zc_s & ~zc_prev_reg;
  // request clamped to full scale, then cut by the current limit
  always @* begin
    lim = (climit_pct > `PCT_FULL) ? `PCT_FULL : climit_pct;
    dem = (setpt_reg > `PCT_FULL) ? `PCT_FULL : setpt_reg;
    if (lim < dem) begin
      dem = lim;
    end
  end
  // digital input functions
  always @* begin
    enable = 1'b1;
    if (din2_func_reg == `F_ENABLE) begin
      enable = din2_s;
    end else if (din1_func_reg == `F_ENABLE) begin
      enable = din1_s;
    end
    follow = (din1_func_reg == `F_FOLLOW) || (din2_func_reg == `F_FOLLOW);
    follow_lvl = (din1_func_reg == `F_FOLLOW) ? din1_s : din2_s;
  end
  // accumulator: per cycle for single and contactor, per run for burst
  assign min_eff = (min_reg == 8'h00) ? 8'h01 : min_reg;
  assign run_end = (run_cnt_reg >= min_eff - 8'h01);
  always @* begin
    acc_pct = follow ? lim : dem;
    acc_step = 1'b0;
    if (full_edge) begin
      if (follow || method_reg == `M_SINGLE) begin
        acc_step = 1'b1;
      end else if (method_reg == `M_BURST || method_reg == `M_RAMP) begin
        acc_step = run_end;
      end
    end
  end
  density_accum u_accum (
    .clk(pclk),
    .rstn(presetn),
    .ce(ce),
    .step(acc_step),
    .pct(acc_pct),
    .fire(fire)
  );
  // time base position for the coming cycle
  assign cycle_eff = (cycle_reg == 16'h0000) ? 16'h0001 : cycle_reg;
  always @* begin
    if (tb_reg + 16'h0001 >= cycle_eff) begin
      tb_next = 16'h0000;
    end else begin
      tb_next = tb_reg + 16'h0001;
    end
  end
  // on while position * full scale is below time base * request
  assign tb_lhs = {7'h00, tb_next} * 23'h000064;
  assign tb_rhs = {7'h00, cycle_eff} * {16'h0000, dem};
  assign zc_on = (tb_lhs < tb_rhs);
  // pattern decided once per line cycle
  always @* begin
    pat_next = pat_reg;
    if (full_edge) begin
      case (method_reg)
        `M_ZC: begin
          pat_next = zc_on;
        end
        `M_SINGLE: begin
          pat_next = fire;
        end
        `M_BURST, `M_RAMP: begin
          pat_next = run_end ? fire : run_on_reg;
        end
        default: begin
          pat_next = 1'b0;
        end
      endcase
    end
  end
  // contactor: follow level, thinned only by the limit accumulator
  assign on_next = follow ?
    (follow_lvl & (full_edge ? fire : lim_on_reg)) : pat_next;

  // new burst after an off run starts a ramp, never with follow
  assign ramp_start = full_edge & ~follow & (method_reg == `M_RAMP) &
    run_end & fire & ~run_on_reg & (ramp_len_reg != 8'h00);
  assign ramp_last = (ramp_cnt_reg + 8'h01 >= ramp_len_reg);

  // conduction window grows with each ramp half cycle
  assign win_lhs = {8'h00, elapsed_reg} * {20'h00000, ramp_len_reg};
  assign win_rhs = {8'h00, period_reg} *
    {20'h00000, ramp_len_reg - 8'h01 - ramp_cnt_reg};
  assign win = (win_lhs >= win_rhs);

  always @* begin
    gate_next = gate_out;
    if (half_edge) begin
      // change at the crossing; a further ramp half waits for its window
      gate_next = on_next & enable & ~ramp_start &
        ~(ramp_reg & ~ramp_last);
    end else if (ramp_reg) begin
      gate_next = win & en_reg & pat_reg;
    end
  end

  // line-cycle pattern state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_prev_reg <= 1'b0;
      tb_reg <= 16'h0000;
      run_cnt_reg <= 8'h00;
      run_on_reg <= 1'b0;
      pat_reg <= 1'b0;
      lim_on_reg <= 1'b0;
      en_reg <= 1'b0;
    end else if (ce) begin
      zc_prev_reg <= zc_s;
      if (half_edge) begin
        en_reg <= enable;
      end
      if (full_edge) begin
        tb_reg <= tb_next;
        lim_on_reg <= fire;
        if (run_end) begin
          run_cnt_reg <= 8'h00;
          run_on_reg <= fire;
        end else begin
          run_cnt_reg <= run_cnt_reg + 8'h01;
        end
      end
      pat_reg <= pat_next;
    end
  end

  // ramp and half-cycle timing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_reg <= 1'b0;
      ramp_cnt_reg <= 8'h00;
      elapsed_reg <= 20'h00000;
      period_reg <= 20'h00000;
    end else if (ce) begin
      if (half_edge) begin
        period_reg <= elapsed_reg;
        elapsed_reg <= 20'h00000;
      end else if (elapsed_reg != `ELAPSED_MAX) begin
        elapsed_reg <= elapsed_reg + 20'h00001;
      end
      if (ramp_start) begin
        ramp_reg <= 1'b1;
        ramp_cnt_reg <= 8'h00;
      end else if (full_edge && !pat_next) begin
        ramp_reg <= 1'b0;
      end else if (half_edge && ramp_reg) begin
        // ramp half cycles are part of the burst run
        if (ramp_last) begin
          ramp_reg <= 1'b0;
        end else begin
          ramp_cnt_reg <= ramp_cnt_reg + 8'h01;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_out <= 1'b0;
      ramp_out <= 1'b0;
    end else if (ce) begin
      gate_out <= gate_next;
      ramp_out <= ramp_reg;
    end
  end

  // apb slave: one wait state, write lands on the ready edge
  assign wr_en = psel & penable & pwrite & pready;

  always @* begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr & 8'hfc)
      `OFS_CTRL: begin
        rd_data[`CTRL_METHOD_LSB +: 2] = method_reg;
        rd_data[`CTRL_DIN1_LSB +: 2] = din1_func_reg;
        rd_data[`CTRL_DIN2_LSB +: 2] = din2_func_reg;
      end
      `OFS_SETPT: begin
        rd_data[6:0] = setpt_reg;
      end
      `OFS_CYCLE: begin
        rd_data[15:0] = cycle_reg;
      end
      `OFS_BURST: begin
        rd_data[`BURST_MIN_LSB +: 8] = min_reg;
        rd_data[`BURST_RAMP_LSB +: 8] = ramp_len_reg;
      end
      `OFS_STATUS: begin
        rd_data[`ST_GATE] = gate_out;
        rd_data[`ST_RAMP] = ramp_reg;
        rd_data[`ST_RUN] = pat_reg;
        rd_data[`ST_EN] = en_reg;
        rd_data[`ST_FOLLOW] = follow;
        rd_data[`ST_DEM_LSB +: 7] = dem;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= ~rd_hit;
        prdata <= pwrite ? 32'h00000000 : rd_data;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      method_reg <= `M_ZC;
      din1_func_reg <= `F_NONE;
      din2_func_reg <= `F_NONE;
      setpt_reg <= `RST_SETPT;
      cycle_reg <= `RST_CYCLE;
      min_reg <= `RST_MIN;
      ramp_len_reg <= `RST_RAMP;
    end else if (ce && wr_en) begin
      case (paddr & 8'hfc)
        `OFS_CTRL: begin
          method_reg <= pwdata[`CTRL_METHOD_LSB +: 2];
          din1_func_reg <= pwdata[`CTRL_DIN1_LSB +: 2];
          din2_func_reg <= pwdata[`CTRL_DIN2_LSB +: 2];
        end
        `OFS_SETPT: begin
          setpt_reg <= pwdata[6:0];
        end
        `OFS_CYCLE: begin
          cycle_reg <= pwdata[15:0];
        end
        `OFS_BURST: begin
          min_reg <= pwdata[`BURST_MIN_LSB +: 8];
          ramp_len_reg <= pwdata[`BURST_RAMP_LSB +: 8];
        end
        default: begin
          method_reg <= method_reg;
        end
      endcase
    end
  end
endmodule

/* File: ac_firing_pattern_generator_tb.sv */
// self-checking bench for the firing pattern generator
// assumes the line model on zc_in and the bound port checker
`timescale 1ns/100ps
module ac_firing_pattern_generator_tb;
  localparam int HALF = 50;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic din1_in = 1'b0;
  logic din2_in = 1'b0;
  logic [6:0] climit_pct = 7'h64;
  wire [31:0] prdata;
  wire pready, pslverr, zc_in, gate_out, ramp_out;
  int on_halves, halves, n;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int ramp_rises = 0;
  logic ramp_q = 1'b0;
  logic [31:0] rd;
  logic err;
  logic [7:0] ra[4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
  logic [31:0] rv[4] = '{32'h0, 32'h0, 32'h258, 32'h604};
  always #5 pclk = ~pclk;
  ac_firing_pattern_generator dut (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .zc_in(zc_in), .din1_in(din1_in),
    .din2_in(din2_in), .climit_pct(climit_pct), .gate_out(gate_out),
    .ramp_out(ramp_out));
  ac_line_model #(.HALF(HALF)) line (.pclk(pclk), .gate_out(gate_out),
    .zc_in(zc_in), .on_halves(on_halves), .halves(halves));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic settle(input int k);
    repeat (k * HALF) @(posedge pclk);
  endtask
  // count conducting halves over the next k halves
  task automatic meas(input int k, input int exp);
    int s;
    int h;
    s = on_halves;
    h = halves;
    while (halves < h + k) @(posedge pclk);
    chk(on_halves - s, exp);
  endtask
  always @(posedge pclk) begin
    cycles++;
    ramp_q <= ramp_out;
    if (ramp_out === 1'b1 && ramp_q !== 1'b1)
      ramp_rises++;
    if (cycles == 80000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h04, 32'h4b);
    climit_pct <= 7'h28;
    apb(1'b0, 8'h10, 32'h0);
    chk({25'h0, rd[14:8]}, 32'h28);
    climit_pct <= 7'h64;
    apb(1'b1, 8'h08, 32'h4);
    settle(16);
    meas(16, 12);
    apb(1'b1, 8'h04, 32'h64);
    settle(8);
    meas(16, 16);
    for (int m = 1; m < 3; m++) begin
      apb(1'b1, 8'h00, m);
      for (int p = 25; p <= 100; p += 25) begin
        apb(1'b1, 8'h04, p);
        settle(32);
        meas(32, p * 32 / 100);
      end
    end
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h04, 32'h0);
    settle(32);
    n = ramp_rises;
    apb(1'b1, 8'h04, 32'h64);
    settle(40);
    chk(ramp_rises - n, 32'h1);
    meas(16, 16);
    apb(1'b1, 8'h00, 32'h08);
    apb(1'b1, 8'h04, 32'h64);
    din1_in <= 1'b1;
    settle(6);
    meas(16, 16);
    din1_in <= 1'b0;
    settle(3);
    meas(16, 0);
    din1_in <= 1'b1;
    climit_pct <= 7'h32;
    apb(1'b1, 8'h04, 32'h0);
    settle(8);
    meas(16, 8);
    climit_pct <= 7'h64;
    apb(1'b1, 8'h00, 32'h15);
    apb(1'b1, 8'h04, 32'h64);
    settle(4);
    meas(16, 0);
    din1_in <= 1'b0;
    din2_in <= 1'b1;
    settle(4);
    meas(16, 16);
    conclude();
  end
endmodule

/* File: ac_line_model.sv */
// ac line and switched load: zero-cross wave, counts conducting halves
// assumes gate_out high makes the switch conduct
`timescale 1ns/100ps
module ac_line_model #(
  parameter int HALF = 50
) (
  input wire logic pclk, // time reference
  input wire logic gate_out, // switch gate from the block
  output logic zc_in, // high in the positive half
  output int on_halves, // halves seen conducting
  output int halves // halves seen
);
  int t = 0;
  initial begin
    zc_in = 1'b0;
    on_halves = 0;
    halves = 0;
  end
  // mains runs free of the block's reset; sample load mid half
  always @(posedge pclk) begin
    t <= (t == 2 * HALF - 1) ? 0 : t + 1;
    zc_in <= (t >= HALF);
    if (t % HALF == HALF / 2) begin
      halves <= halves + 1;
      on_halves <= on_halves + (gate_out === 1'b1);
    end
  end
endmodule

/* File: acfpg_chk_sva.sv */
// port checker for the firing pattern generator
// assumes one pclk domain; bound to the block below
`timescale 1ns/100ps
module acfpg_chk (
  input wire pclk, // clock
  input wire presetn, // async reset, active low
  input wire ce, // clock enable
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [7:0] paddr, // apb address
  input wire [31:0] prdata, // apb read data
  input wire pready, // apb ready
  input wire pslverr, // apb error
  input wire zc_in, // zero cross square wave
  input wire gate_out, // switch gate
  input wire ramp_out // start ramp flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rdy_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_rdy_wait: assert property (psel && penable && !pready && ce
    && $past(psel && !penable) |=> pready)
    else $error("pready missing after one wait state");
  a_rdy_idle: assert property (!psel |=> !pready)
    else $error("pready without a transfer");
  a_err_map: assert property (pready |-> pslverr == (paddr > 8'h13))
    else $error("pslverr does not match the address map");
  a_err_data: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_rd_unused: assert property (pready && !pwrite && paddr == 8'h04
    |-> prdata[31:7] == 25'h0)
    else $error("unused setpoint bits read nonzero");
  a_gate_zc: assert property (
    $changed(gate_out) && !ramp_out && !$past(ramp_out)
    |-> $past(zc_in, 3) != $past(zc_in, 6))
    else $error("gate changed away from a zero crossing");
  a_ramp_start: assert property ($rose(ramp_out) |-> !gate_out)
    else $error("ramp began with the gate already on");
  a_reset_quiet: assert property (@(posedge pclk) disable iff (1'b0)
    !presetn |-> !gate_out && !pready && !ramp_out)
    else $error("outputs active during reset");
endmodule
bind ac_firing_pattern_generator acfpg_chk chk (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .zc_in(zc_in), .gate_out(gate_out),
  .ramp_out(ramp_out));

/* File: acfpg_consts.vh */
// register map, field positions, reset values and codes of the firing
// pattern generator; included by the design files
`ifndef ACFPG_CONSTS_VH
`define ACFPG_CONSTS_VH

// byte offsets of the registers
`define OFS_CTRL 8'h00
`define OFS_SETPT 8'h04
`define OFS_CYCLE 8'h08
`define OFS_BURST 8'h0c
`define OFS_STATUS 8'h10

// control register fields
`define CTRL_METHOD_LSB 0
`define CTRL_DIN1_LSB 2
`define CTRL_DIN2_LSB 4

// burst register fields
`define BURST_MIN_LSB 0
`define BURST_RAMP_LSB 8

// status register fields
`define ST_GATE 0
`define ST_RAMP 1
`define ST_RUN 2
`define ST_EN 3
`define ST_FOLLOW 4
`define ST_DEM_LSB 8

// reset values
`define RST_CTRL 6'h00
`define RST_SETPT 7'h00
`define RST_CYCLE 16'h0258
`define RST_MIN 8'h04
`define RST_RAMP 8'h06

// firing methods
`define M_ZC 2'h0
`define M_SINGLE 2'h1
`define M_BURST 2'h2
`define M_RAMP 2'h3

// digital input functions
`define F_NONE 2'h0
`define F_ENABLE 2'h1
`define F_FOLLOW 2'h2

// full scale request, percent
`define PCT_FULL 7'h64

// saturation of the half-cycle length counter
`define ELAPSED_MAX 20'hfffff

`endif

/* File: density_accum.v */
// fractional accumulator that spreads on decisions evenly over steps
// assumes pct never exceeds full scale; step is a one-cycle pulse
`timescale 1ns/100ps
`include "acfpg_consts.vh"
module density_accum (
  input wire clk, // clock
  input wire rstn, // async reset, active low
  input wire ce, // clock enable
  input wire step, // advance one decision
  input wire [6:0] pct, // requested share, 0 to full scale
  output wire fire // decision for the current step
);
  reg [6:0] acc_reg;
  wire [7:0] sum;

  assign sum = {1'b0, acc_reg} + {1'b0, pct};
  assign fire = (sum >= {1'b0, `PCT_FULL});

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= 7'h00;
    end else if (ce && step) begin
      if (fire) begin
        acc_reg <= sum[6:0] - `PCT_FULL;
      end else begin
        acc_reg <= sum[6:0];
      end
    end
  end
endmodule

/* File: sync2.v */
// two flip-flop synchroniser for a group of level inputs
// assumes inputs are quasi-static levels from outside the pclk domain
`timescale 1ns/100ps
module sync2 #(
  parameter W = 1
) (
  input wire clk, // sampling clock
  input wire rstn, // async reset, active low
  input wire ce, // clock enable
  input wire [W-1:0] d, // asynchronous levels
  output reg [W-1:0] q // synchronised levels
);
  reg [W-1:0] meta_reg;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
